// ==== design/ssts_pkg.sv ====
`default_nettype none
package ssts_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICKS_PER_S = 1000 / TICK_MS;
    localparam int unsigned TW = 12;
    // preset step lengths in seconds; an uninterrupted run is their sum
    localparam int unsigned IL_ON_S = 75;
    localparam int unsigned IL_OFF_S = 75;
    localparam int unsigned BY_ON_S = 75;
    localparam int unsigned BY_OFF_S = 60;
    localparam int unsigned TOTAL_S = IL_ON_S + IL_OFF_S + BY_ON_S + BY_OFF_S;
    localparam int unsigned DONE_MSG_S = 3;
    localparam logic [7:0] A_MISC_CMD = 8'h00;
    localparam logic [7:0] A_CONFIG = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] A_IRQ_MASK = 8'h10;
    localparam logic [7:0] A_LAST_EVENT = 8'h14;
    localparam int unsigned CFG_IL_FB = 0;
    localparam int unsigned CFG_BY_FB = 1;
    localparam int unsigned CFG_BYR_ON = 2;
    localparam int unsigned CFG_BYR_FAN = 3;
    localparam int unsigned CFG_IL_TO = 8;
    localparam int unsigned CFG_BY_TO = 16;
    localparam logic [31:0] CFG_RESET = 32'h000A_0A00;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_ENTER = 0;
    localparam int unsigned IRQ_PASS = 1;
    localparam int unsigned IRQ_FAULT = 2;
    localparam int unsigned IRQ_ABORT = 3;
    localparam logic [7:0] EV_ENTER = 8'hC1;
    localparam logic [7:0] EV_PASS = 8'hC3;
    localparam logic [7:0] FLT_INLINE = 8'h31;
    localparam logic [7:0] FLT_BYPASS = 8'h30;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_LOG = 4'h1, S_WAIT = 4'h3, S_IL_ON = 4'h2, S_IL_OFF = 4'h6,
        S_BY_ON = 4'h7, S_BY_OFF = 4'h5, S_DONE = 4'h4, S_FAULT = 4'h8
    } ssts_state_e;
    typedef enum logic [3:0] {
        D_HOME = 4'h0, D_OPEN_DISC = 4'h1, D_IL_CLOSED = 4'h2, D_IL_OPEN = 4'h3,
        D_BY_CLOSED = 4'h4, D_BY_OPEN = 4'h5, D_DONE = 4'h6, D_FAULT = 4'h7, D_ENTER = 4'h8
    } ssts_disp_e;
    function automatic ssts_disp_e disp_of(input ssts_state_e s);
        case (s)
            S_LOG: disp_of = D_ENTER;
            S_WAIT: disp_of = D_OPEN_DISC;
            S_IL_ON: disp_of = D_IL_CLOSED;
            S_IL_OFF: disp_of = D_IL_OPEN;
            S_BY_ON: disp_of = D_BY_CLOSED;
            S_BY_OFF: disp_of = D_BY_OPEN;
            S_DONE: disp_of = D_DONE;
            S_FAULT: disp_of = D_FAULT;
            default: disp_of = D_HOME;
        endcase
    endfunction
    function automatic logic [TW-1:0] step_ticks(input ssts_state_e s);
        case (s)
            S_IL_ON: step_ticks = TW'(IL_ON_S * TICKS_PER_S);
            S_IL_OFF: step_ticks = TW'(IL_OFF_S * TICKS_PER_S);
            S_BY_ON: step_ticks = TW'(BY_ON_S * TICKS_PER_S);
            S_BY_OFF: step_ticks = TW'(BY_OFF_S * TICKS_PER_S);
            S_DONE: step_ticks = TW'(DONE_MSG_S * TICKS_PER_S);
            default: step_ticks = '0;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== design/ssts_chk_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ssts_chk_if;
    logic restart;
    logic en;
    logic exp_lvl;
    logic fb;
    logic tick;
    logic [7:0] timeout;
    logic fault;
    modport seq (output restart, en, exp_lvl, fb, tick, timeout, input fault);
    modport chk (input restart, en, exp_lvl, fb, tick, timeout, output fault);
endinterface
`default_nettype wire

// ==== design/ssts_step_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssts_step_timer #(
    parameter int unsigned TICK_CYC = ssts_pkg::TICK_CYC,
    parameter int unsigned TW = ssts_pkg::TW
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [TW-1:0] i_load_val,
    output logic o_tick,
    output logic o_expire
);
    localparam int unsigned PW = $clog2(TICK_CYC + 1);
    logic [PW-1:0] pre_q;
    logic [TW-1:0] cnt_q;
    logic tick_q;
    logic exp_q;
    wire pre_end = (pre_q == PW'(TICK_CYC - 1));
    // prescaler restarts on load so every step lasts its preset plus two clock cycles
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_q <= '0;
            cnt_q <= '0;
            tick_q <= 1'b0;
            exp_q <= 1'b0;
        end else if (i_ce) begin
            if (i_load) begin
                pre_q <= '0;
                cnt_q <= i_load_val;
                tick_q <= 1'b0;
                exp_q <= 1'b0;
            end else begin
                pre_q <= pre_end ? '0 : pre_q + PW'(1);
                tick_q <= pre_end;
                exp_q <= tick_q && (cnt_q == TW'(1));
                if (tick_q && (cnt_q != '0)) begin
                    cnt_q <= cnt_q - TW'(1);
                end
            end
        end
    end
    assign o_tick = tick_q;
    assign o_expire = exp_q;
endmodule // ssts_step_timer
`default_nettype wire

// ==== design/ssts_fb_check.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssts_fb_check (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    ssts_chk_if.chk bus
);
    logic [7:0] cnt_q;
    logic seen_q;
    logic fault_q;
    wire mism = bus.en && !seen_q && (bus.fb != bus.exp_lvl);
    // a timeout of zero disables the check; the 8-bit counter would otherwise wrap onto it
    wire hit = mism && bus.tick && (bus.timeout != 8'h00) && ((cnt_q + 8'h01) == bus.timeout);
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            seen_q <= 1'b0;
            fault_q <= 1'b0;
        end else if (i_ce) begin
            // a step that ends on this edge must not hand its fault to the next step
            fault_q <= hit && !bus.restart;
            if (bus.restart || !bus.en) begin
                cnt_q <= '0;
                seen_q <= 1'b0;
            end else if (bus.fb == bus.exp_lvl) begin
                seen_q <= 1'b1;
            end else if (mism && bus.tick && !hit) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
    assign bus.fault = fault_q;
endmodule // ssts_fb_check
`default_nettype wire

// ==== design/ssts_sequencer.sv ====
// Notes on behaviour
// - self-test starts only with the standard setting written and Enter pressed
// - the entry event is logged before any test step runs
// - while the disconnect reads closed, prompt to open it and hold
// - the display shows the active step and follows every transition
// - an Enter press ends the current step early and advances
// - step presets add up to 285 seconds for an uninterrupted run
// - on completion show a done message briefly, then the home screen
// - the in-line contactor step runs before the bypass step
// - run relays switch on then off once; feedback checked in both states
// - in-line feedback mismatch past its timeout raises the in-line fault
// - with no in-line feedback input configured, the in-line step passes
// - in-line timeout set to off skips the in-line step
// - bypass relay if assigned and at-speed relays cycle once, both checked
// - bypass feedback mismatch past its timeout raises the bypass fault
// - fan-duty bypass relay with no bypass feedback input passes the step
// - disconnect closing, line power or command removal aborts and logs cause
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module ssts_sequencer #(
    parameter int unsigned P_TICK_CYC = ssts_pkg::TICK_CYC,
    parameter logic [7:0] P_STD_SETTING = 8'h07,
    parameter logic [7:0] P_FLT_DISC = 8'h0A,
    parameter logic [7:0] P_FLT_LINE = 8'h0B,
    parameter logic [7:0] P_FLT_CMD = 8'h0C
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_enter_key,
    input wire logic i_disc_closed,
    input wire logic i_line_power,
    input wire logic i_inline_fb,
    input wire logic i_bypass_fb,
    output logic o_run_relay,
    output logic o_at_speed_relay,
    output logic o_bypass_relay,
    output ssts_pkg::ssts_disp_e o_display_code,
    output logic o_event_stb,
    output logic [7:0] o_event_code,
    output logic o_irq
);
    import ssts_pkg::*;

    ssts_state_e st_q;
    ssts_state_e st_d;
    logic [7:0] misc_cmd_q;
    logic [31:0] cfg_q;
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic run_q;
    logic at_speed_q;
    logic byp_relay_q;
    ssts_disp_e disp_q;
    logic ev_stb_q;
    logic [7:0] ev_code_q;
    logic irq_q;
    logic ev_stb_d;
    logic [7:0] ev_code_d;
    logic [31:0] rd_d;
    logic rd_err;
    logic [IRQ_W-1:0] irq_set;
    logic tick;
    logic expire;

    ssts_chk_if chk ();

    // bus decode
    wire setup = i_psel && !i_penable;
    wire wr_en = i_psel && i_penable && i_pwrite && pready_q;
    wire wr_misc = wr_en && (i_paddr == A_MISC_CMD);
    wire wr_cfg = wr_en && (i_paddr == A_CONFIG);
    wire wr_w1c = wr_en && (i_paddr == A_IRQ_STATUS);
    wire wr_mask = wr_en && (i_paddr == A_IRQ_MASK);

    // configuration fields
    wire il_fb_on = cfg_q[CFG_IL_FB];
    wire by_fb_on = cfg_q[CFG_BY_FB];
    wire byr_on = cfg_q[CFG_BYR_ON];
    wire byr_fan = cfg_q[CFG_BYR_FAN];
    wire [7:0] il_to = cfg_q[CFG_IL_TO +: 8];
    wire [7:0] by_to = cfg_q[CFG_BY_TO +: 8];
    wire il_skip = (il_to == 8'h00);
    wire by_check = !(byr_fan && !by_fb_on);

    // sequence conditions
    wire cmd_ok = (misc_cmd_q == P_STD_SETTING);
    wire in_il = (st_q == S_IL_ON) || (st_q == S_IL_OFF);
    wire in_by = (st_q == S_BY_ON) || (st_q == S_BY_OFF);
    wire in_step = in_il || in_by;
    wire abort = in_step && (i_disc_closed || i_line_power || !cmd_ok);
    wire [7:0] abort_code = i_disc_closed ? P_FLT_DISC : (i_line_power ? P_FLT_LINE : P_FLT_CMD);
    wire advance = i_enter_key || expire;
    wire load = (st_d != st_q);
    wire done_pass = (st_q == S_DONE) && expire;

    // feedback checker hookup; relays and state change on the same edge
    assign chk.restart = load;
    assign chk.en = (in_il && il_fb_on) || (in_by && by_check);
    assign chk.exp_lvl = in_il ? run_q : at_speed_q;
    assign chk.fb = in_il ? i_inline_fb : i_bypass_fb;
    assign chk.timeout = in_il ? il_to : by_to;
    assign chk.tick = tick;

    assign irq_set[IRQ_ENTER] = i_ce && (st_q == S_LOG);
    assign irq_set[IRQ_PASS] = i_ce && done_pass;
    assign irq_set[IRQ_FAULT] = i_ce && in_step && !abort && chk.fault;
    assign irq_set[IRQ_ABORT] = i_ce && abort;

    ssts_step_timer #(
        .TICK_CYC(P_TICK_CYC),
        .TW(TW)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_load(load),
        .i_load_val(step_ticks(st_d)),
        .o_tick(tick),
        .o_expire(expire)
    );

    ssts_fb_check u_check (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .bus(chk.chk)
    );

    // abort outranks a feedback fault, which outranks an advance
    always_comb begin
        st_d = st_q;
        ev_stb_d = 1'b0;
        ev_code_d = ev_code_q;
        case (st_q)
            S_IDLE: begin
                if (i_enter_key && cmd_ok) begin
                    st_d = S_LOG;
                end
            end
            S_LOG: begin
                st_d = S_WAIT;
                ev_stb_d = 1'b1;
                ev_code_d = EV_ENTER;
            end
            S_WAIT: begin
                if (!cmd_ok) begin
                    st_d = S_IDLE;
                end else if (!i_disc_closed) begin
                    st_d = il_skip ? S_BY_ON : S_IL_ON;
                end
            end
            S_IL_ON, S_IL_OFF, S_BY_ON, S_BY_OFF: begin
                if (abort) begin
                    st_d = S_FAULT;
                    ev_stb_d = 1'b1;
                    ev_code_d = abort_code;
                end else if (chk.fault) begin
                    st_d = S_FAULT;
                    ev_stb_d = 1'b1;
                    ev_code_d = in_il ? FLT_INLINE : FLT_BYPASS;
                end else if (advance) begin
                    case (st_q)
                        S_IL_ON: st_d = S_IL_OFF;
                        S_IL_OFF: st_d = S_BY_ON;
                        S_BY_ON: st_d = S_BY_OFF;
                        default: st_d = S_DONE;
                    endcase
                end
            end
            S_DONE: begin
                if (expire) begin
                    st_d = S_IDLE;
                    ev_stb_d = 1'b1;
                    ev_code_d = EV_PASS;
                end
            end
            S_FAULT: begin
                // software must change the command before a new run
                if (!cmd_ok) begin
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_comb begin
        rd_d = '0;
        rd_err = 1'b0;
        if (i_paddr == A_MISC_CMD) begin
            rd_d = {24'h00_0000, misc_cmd_q};
        end else if (i_paddr == A_CONFIG) begin
            rd_d = cfg_q;
        end else if (i_paddr == A_STATUS) begin
            rd_d = {16'h0000, 4'h0, byp_relay_q, at_speed_q, run_q, i_disc_closed, disp_q, st_q};
        end else if (i_paddr == A_IRQ_STATUS) begin
            rd_d = {28'h000_0000, irq_st_q};
        end else if (i_paddr == A_IRQ_MASK) begin
            rd_d = {28'h000_0000, irq_mask_q};
        end else if (i_paddr == A_LAST_EVENT) begin
            rd_d = {24'h00_0000, ev_code_q};
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (i_ce) begin
            pready_q <= setup;
            pslverr_q <= setup && rd_err;
            if (setup) begin
                prdata_q <= i_pwrite ? 32'h0000_0000 : rd_d;
            end
        end
    end

    // a software write of the command wins over the clear after a pass
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            misc_cmd_q <= 8'h00;
            cfg_q <= CFG_RESET;
            irq_mask_q <= '0;
            irq_st_q <= '0;
            irq_q <= 1'b0;
        end else if (i_ce) begin
            if (wr_misc) begin
                misc_cmd_q <= i_pwdata[7:0];
            end else if (done_pass) begin
                misc_cmd_q <= 8'h00;
            end
            if (wr_cfg) begin
                cfg_q <= i_pwdata;
            end
            if (wr_mask) begin
                irq_mask_q <= i_pwdata[IRQ_W-1:0];
            end
            irq_st_q <= (irq_st_q & ~(wr_w1c ? i_pwdata[IRQ_W-1:0] : '0)) | irq_set;
            irq_q <= |(((irq_st_q & ~(wr_w1c ? i_pwdata[IRQ_W-1:0] : '0)) | irq_set) & irq_mask_q);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= S_IDLE;
            run_q <= 1'b0;
            at_speed_q <= 1'b0;
            byp_relay_q <= 1'b0;
            disp_q <= D_HOME;
            ev_stb_q <= 1'b0;
            ev_code_q <= 8'h00;
        end else if (i_ce) begin
            st_q <= st_d;
            run_q <= (st_d == S_IL_ON);
            at_speed_q <= (st_d == S_BY_ON);
            byp_relay_q <= (st_d == S_BY_ON) && byr_on && !byr_fan;
            disp_q <= disp_of(st_d);
            ev_stb_q <= ev_stb_d;
            ev_code_q <= ev_code_d;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_run_relay = run_q;
    assign o_at_speed_relay = at_speed_q;
    assign o_bypass_relay = byp_relay_q;
    assign o_display_code = disp_q;
    assign o_event_stb = ev_stb_q;
    assign o_event_code = ev_code_q;
    assign o_irq = irq_q;

    a_entry_cause: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_q == S_LOG && $past(st_q) == S_IDLE) |-> $past(i_enter_key) && $past(cmd_ok))
        else $error("self-test entered without command and enter");

    a_entry_logged: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_q == S_LOG && i_ce) |=> o_event_stb && o_event_code == EV_ENTER && st_q == S_WAIT)
        else $error("entry event not logged");

    a_disc_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_q == S_WAIT && i_disc_closed && i_ce) |=>
            (st_q == S_WAIT || st_q == S_IDLE) && !o_run_relay && !o_at_speed_relay)
        else $error("test steps started with disconnect closed");

    a_display_step: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_ce && st_d != st_q) |=> o_display_code == disp_of(st_q))
        else $error("display not following step");

    a_enter_advance: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_q == S_IL_ON && i_enter_key && i_ce && !abort && !chk.fault) |=>
            st_q == S_IL_OFF && !o_run_relay)
        else $error("enter did not advance step");

    a_step_expire: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_q == S_BY_OFF && expire && i_ce && !abort && !chk.fault) |=> st_q == S_DONE)
        else $error("expired step did not advance");

    a_relay_states: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_q == S_IL_ON |-> o_run_relay) and (st_q == S_IL_OFF |-> !o_run_relay))
        else $error("run relay not matching step");

    a_inline_fault: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (in_il && chk.fault && !abort && i_ce) |=>
            st_q == S_FAULT && o_event_stb && o_event_code == FLT_INLINE)
        else $error("in-line fault not raised");

    a_abort_cause: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (abort && i_ce) |=> st_q == S_FAULT && o_event_stb && o_event_code == $past(abort_code))
        else $error("abort not logged");

    a_inline_skip: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_q == S_WAIT && cmd_ok && !i_disc_closed && il_skip && i_ce) |=>
            st_q == S_BY_ON && o_at_speed_relay)
        else $error("in-line step not skipped");

    a_done_home: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (done_pass && i_ce) |=> o_display_code == D_HOME && o_event_code == EV_PASS)
        else $error("no return to home screen");
endmodule // ssts_sequencer
`default_nettype wire

// ==== sim/ssts_contactor_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssts_contactor_model (
    input wire logic i_ref_clk,
    input wire logic i_run,
    input wire logic i_at_speed,
    input wire logic [1:0] i_stuck,
    input wire logic [7:0] i_dly,
    output logic o_il_fb,
    output logic o_by_fb
);
    int il_n = 0;
    int by_n = 0;
    initial begin
        o_il_fb = 1'b0;
        o_by_fb = 1'b0;
    end
    // aux contacts lag the coil; a stuck contact reads open whatever the coil does
    always @(posedge i_ref_clk) begin
        il_n <= (o_il_fb === i_run) ? 0 : il_n + 1;
        by_n <= (o_by_fb === i_at_speed) ? 0 : by_n + 1;
        if (i_stuck[0])
            o_il_fb <= 1'b0;
        else if (il_n >= int'(i_dly))
            o_il_fb <= i_run;
        if (i_stuck[1])
            o_by_fb <= 1'b0;
        else if (by_n >= int'(i_dly))
            o_by_fb <= i_at_speed;
    end
endmodule // ssts_contactor_model
`default_nettype wire

// ==== sim/ssts_sequencer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssts_sequencer_tb;
    import ssts_pkg::*;
    localparam int TC = 10;
    localparam logic [7:0] STD = 8'h07;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic ent = 1'b0;
    logic disc = 1'b0;
    logic line = 1'b0;
    logic ce = 1'b1;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic rdy, serr, err, ilfb, byfb, run, atsp, byp, stb, irq, ia;
    logic [1:0] stuck = 2'b00;
    logic [7:0] dly = 8'h04;
    logic [7:0] code;
    logic [7:0] evq[$];
    logic [31:0] cf [3] = '{32'h000A_0A01, 32'h000A_0A02, 32'h000A_0A0C};
    logic [7:0] fe [2] = '{8'h31, 8'h30};
    ssts_disp_e disp;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    ssts_sequencer #(.P_TICK_CYC(TC), .P_STD_SETTING(STD)) i_ssts_sequencer (
        .i_ref_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(serr), .i_enter_key(ent), .i_disc_closed(disc), .i_line_power(line),
        .i_inline_fb(ilfb), .i_bypass_fb(byfb), .o_run_relay(run), .o_at_speed_relay(atsp),
        .o_bypass_relay(byp), .o_display_code(disp), .o_event_stb(stb),
        .o_event_code(code), .o_irq(irq));
    ssts_contactor_model i_ssts_contactor_model (.i_ref_clk(clk), .i_run(run),
        .i_at_speed(atsp), .i_stuck(stuck), .i_dly(dly), .o_il_fb(ilfb), .o_by_fb(byfb));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stb === 1'b1)
            evq.push_back(code);
        if (cyc == 90000) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        err = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic press();
        @(posedge clk);
        ent <= 1'b1;
        @(posedge clk);
        ent <= 1'b0;
    endtask
    task automatic wait_disp(input ssts_disp_e e, input int n);
        for (int i = 0; i < n && disp !== e; i++) begin
            @(posedge clk);
            #1;
        end
        chk({28'h0, disp}, {28'h0, e}, "display");
    endtask
    task automatic chk_ev(input logic [7:0] e);
        for (int i = 0; i < 400 && evq.size() == 0; i++)
            @(posedge clk);
        if (evq.size() == 0)
            evq.push_back(8'hFF);
        chk({24'h0, evq.pop_front()}, {24'h0, e}, "event");
    endtask
    task automatic start();
        apb(1'b1, A_MISC_CMD, {24'h0, STD});
        evq.delete();
        press();
        chk_ev(8'hC1);
    endtask
    initial begin
        void'($urandom(29));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, A_CONFIG, 32'h0);
        chk(rd, CFG_RESET, "cfg");
        apb(1'b0, 8'h3C, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        press();
        repeat (5) @(posedge clk);
        chk({27'h0, disp, stb}, 32'h0, "no entry");
        $display("test reset done");
        apb(1'b1, A_CONFIG, 32'h000A_0A07);
        disc <= 1'b1;
        dly <= 8'($urandom_range(16, 1));
        start();
        wait_disp(D_OPEN_DISC, 5);
        repeat (50) @(posedge clk);
        chk({27'h0, disp, run}, {27'h0, D_OPEN_DISC, 1'b0}, "held");
        apb(1'b0, A_STATUS, 32'h0);
        chk(rd, {23'h0, 1'b1, D_OPEN_DISC, S_WAIT}, "status");
        disc <= 1'b0;
        wait_disp(D_IL_CLOSED, 5);
        chk({31'h0, run}, 32'h1, "run");
        @(posedge clk);
        ce <= 1'b0;
        press();
        repeat (20) @(posedge clk);
        chk({27'h0, disp, run}, {27'h0, D_IL_CLOSED, 1'b1}, "frozen");
        ce <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            repeat ($urandom_range(60, 20)) @(posedge clk);
            press();
            wait_disp(ssts_disp_e'(k + 3), 3);
            chk({29'h0, run, atsp, byp}, (k == 1) ? 32'h3 : 32'h0, "relays");
        end
        wait_disp(D_HOME, 400);
        chk_ev(8'hC3);
        apb(1'b0, A_MISC_CMD, 32'h0);
        chk(rd, 32'h0, "cmd");
        apb(1'b0, A_IRQ_STATUS, 32'h0);
        chk(rd, 32'h3, "irq st");
        apb(1'b1, A_IRQ_MASK, 32'hF);
        repeat (2) @(posedge clk);
        ia = irq;
        apb(1'b1, A_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, ia ^ irq}, 32'h1, "mask");
        apb(1'b0, A_LAST_EVENT, 32'h0);
        chk(rd, 32'hC3, "last event");
        apb(1'b1, A_IRQ_MASK, 32'hF);
        apb(1'b1, A_IRQ_STATUS, 32'hF);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq");
        apb(1'b0, A_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0, "w1c");
        $display("test stepped run done");
        start();
        wait_disp(D_IL_CLOSED, 5);
        t0 = cyc;
        wait_disp(D_DONE, 29000);
        chk(32'((cyc - t0) > 285 * 10 * TC - 10 && (cyc - t0) < 285 * 10 * TC + 10), 32'h1,
            "length");
        wait_disp(D_HOME, 400);
        chk_ev(8'hC3);
        $display("test timed run done");
        for (int f = 0; f < 3; f++) begin
            apb(1'b1, A_CONFIG, cf[f]);
            stuck <= 2'(f + 1);
            start();
            repeat ((f == 0) ? 0 : 2) begin
                repeat (150) @(posedge clk);
                press();
            end
            if (f < 2) begin
                chk_ev(fe[f]);
                wait_disp(D_FAULT, 3);
            end else begin
                repeat (300) @(posedge clk);
                wait_disp(D_BY_CLOSED, 1);
            end
            stuck <= 2'b00;
            apb(1'b1, A_MISC_CMD, 32'h0);
            wait_disp(D_HOME, 10);
        end
        $display("test feedback done");
        apb(1'b1, A_CONFIG, 32'h000A_0007);
        for (int k = 0; k < 3; k++) begin
            start();
            wait_disp(D_BY_CLOSED, 5);
            @(posedge clk);
            if (k == 0)
                disc <= 1'b1;
            else if (k == 1)
                line <= 1'b1;
            else
                apb(1'b1, A_MISC_CMD, 32'h0);
            chk_ev(8'h0A + 8'(k));
            disc <= 1'b0;
            line <= 1'b0;
            apb(1'b1, A_MISC_CMD, 32'h0);
            wait_disp(D_HOME, 10);
        end
        $display("test abort done");
        results();
    end
endmodule // ssts_sequencer_tb
`default_nettype wire
